// ### hdl/pic_ctrl.sv
// interrupt controller: flags, enables, priorities, arbitration and vector load
`timescale 1ns/100ps
module pic_ctrl
   import pic_pkg::*;
#(
   parameter int TREE_W = 64
)
(
   input  wire logic                CLOCK,
   input  wire logic                RST_N,
   input  wire logic                CLK_EN,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [7:0]          PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic      [31:0]         PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic [NUM_SRC-1:0]  SRC_EVENT,
   input  wire logic [NUM_TRAP-1:0] TRAP_EVENT,
   input  wire logic                INSN_START,
   input  wire logic                TIMED_MASK_START,
   input  wire logic [13:0]         TIMED_MASK_COUNT,
   input  wire logic                IRQ_RETURN,
   input  wire logic [7:0]          RETURN_STATUS_LOW,
   input  wire logic                CORE_SET_LEVEL,
   input  wire logic [3:0]          CORE_LEVEL,
   input  wire logic [23:0]         FETCH_ADDR,
   input  wire logic                FETCH_VALID,
   input  wire logic [23:0]         PROG_RDATA,
   input  wire logic                PROG_RVALID,
   output logic      [23:0]         PROG_ADDR,
   output logic                     PROG_REQ,
   output logic                     PC_LOAD,
   output logic      [23:0]         PC_VALUE,
   output logic                     STACK_PUSH,
   output logic      [23:0]         STACK_PC,
   output logic      [7:0]          STACK_STATUS_LOW,
   output logic      [3:0]          CPU_PRIORITY_LEVEL,
   output logic                     IN_SERVICE,
   output logic                     ADDR_ERR_TRAP
);
   typedef struct packed {
      logic [NUM_SRC-1:0]           flags;
      logic [NUM_SRC-1:0]           enables;
      logic [NUM_PRI_REGS-1:0][15:0] pri;
      logic [15:0]                  ctrl1;
      logic [15:0]                  ctrl2;
      logic [5:0]                   vec_num;
      logic [3:0]                   new_lvl;
      logic [3:0]                   cpu_lvl;
      logic [NUM_TRAP-1:0]          trap_pend;
      logic [13:0]                  tmask_cnt;
      logic [3:0]                   depth;
      pic_state_t                   state;
      logic [31:0]                  rdata;
      logic                         pc_load;
      logic [23:0]                  pc_value;
      logic                         push;
      logic [23:0]                  push_pc;
      logic [7:0]                   push_sl;
      logic                         addr_err;
   } pic_regs_t;

   pic_regs_t r;
   pic_regs_t next_r;

   // arbitration tree over per-source candidates
   logic [TREE_W-1:0]      t_valid [0:6];
   logic [TREE_W-1:0][2:0] t_lvl   [0:6];
   logic [TREE_W-1:0][5:0] t_src   [0:6];

   genvar gi;
   genvar gl;
   generate
      for (gi = 0; gi < TREE_W; gi++) begin : g_leaf
         if (gi < NUM_SRC) begin : g_src
            logic [2:0] lvl;
            assign lvl            = r.pri[gi/4][(gi%4)*4 +: 3];
            // pending, enabled, implemented and nonzero priority
            assign t_valid[0][gi] = r.flags[gi] && r.enables[gi]
                                    && SRC_IMPL_MASK[gi] && (lvl != 3'h0);
            assign t_lvl[0][gi]   = lvl;
            assign t_src[0][gi]   = 6'(gi);
         end else begin : g_pad
            assign t_valid[0][gi] = 1'b0;
            assign t_lvl[0][gi]   = 3'h0;
            assign t_src[0][gi]   = 6'h00;
         end
      end
      for (gl = 0; gl < 6; gl++) begin : g_lvl
         for (gi = 0; gi < (TREE_W >> (gl + 1)); gi++) begin : g_cell
            pic_prio_cell u_cell (
               .A_VALID (t_valid[gl][2*gi]),
               .A_LVL   (t_lvl[gl][2*gi]),
               .A_SRC   (t_src[gl][2*gi]),
               .B_VALID (t_valid[gl][2*gi+1]),
               .B_LVL   (t_lvl[gl][2*gi+1]),
               .B_SRC   (t_src[gl][2*gi+1]),
               .Y_VALID (t_valid[gl+1][gi]),
               .Y_LVL   (t_lvl[gl+1][gi]),
               .Y_SRC   (t_src[gl+1][gi])
            );
         end
         for (gi = (TREE_W >> (gl + 1)); gi < TREE_W; gi++) begin : g_zero
            assign t_valid[gl+1][gi] = 1'b0;
            assign t_lvl[gl+1][gi]   = 3'h0;
            assign t_src[gl+1][gi]   = 6'h00;
         end
      end
   endgenerate

   logic       win_valid;
   logic [2:0] win_lvl;
   logic [5:0] win_src;
   assign win_valid = t_valid[6][0];
   assign win_lvl   = t_lvl[6][0];
   assign win_src   = t_src[6][0];

   // apb decode
   logic       apb_acc;
   logic       apb_wr;
   logic       hit_pri;
   logic [3:0] pri_idx;
   logic       mapped;
   logic [7:0] pri_off;
   assign apb_acc = PSEL && PENABLE;
   assign apb_wr  = apb_acc && PWRITE;
   assign pri_off = PADDR - OFS_PRI0;
   assign pri_idx = pri_off[5:2];
   assign hit_pri = (PADDR >= OFS_PRI0) && (pri_idx < 4'(NUM_PRI_REGS)) && (PADDR[1:0] == 2'b00);
   always_comb begin
      unique case (PADDR)
         OFS_FLAGS0, OFS_FLAGS1, OFS_FLAGS2, OFS_EN0, OFS_EN1, OFS_EN2,
         OFS_CTRL1, OFS_CTRL2, OFS_VSTAT, OFS_CPUPRI, OFS_TMASK: mapped = 1'b1;
         default: mapped = hit_pri;
      endcase
   end

   // candidate trap and interrupt
   logic [1:0] trap_idx;
   logic       trap_any;
   logic [3:0] cand_lvl;
   logic [5:0] cand_vec;
   logic       tmask_on;
   logic       take;
   always_comb begin
      trap_idx = 2'd0;
      for (int i = 0; i < NUM_TRAP; i++) begin
         if (r.trap_pend[i]) begin
            trap_idx = 2'(i);
         end
      end
      trap_any = |r.trap_pend;
      tmask_on = r.ctrl2[CTRL2_TMASK];
      if (trap_any) begin
         cand_lvl = TRAP_LVL_BASE + 4'({2'b00, trap_idx}) + 4'h3;
         cand_vec = 6'({4'h0, trap_idx}) + 6'h1;
      end else begin
         cand_lvl = {1'b0, win_lvl};
         cand_vec = win_src + VEC_BASE;
      end
      take = INSN_START && (trap_any || win_valid)
             && (cand_lvl > r.cpu_lvl)
             && !(r.ctrl1[CTRL1_NEST_DIS] && (r.depth != 4'h0) && !trap_any)
             && !(tmask_on && !trap_any && (win_lvl <= TIMED_MASK_LVL));
   end

   always_comb begin
      logic [15:0] wd;
      wd     = PWDATA[15:0];
      next_r = r;
      next_r.pc_load  = 1'b0;
      next_r.push     = 1'b0;
      next_r.addr_err = 1'b0;
      // flag clears by software, then hardware sets win
      if (apb_wr && PADDR == OFS_FLAGS0) next_r.flags[15:0]  = r.flags[15:0] & wd;
      if (apb_wr && PADDR == OFS_FLAGS1) next_r.flags[31:16] = r.flags[31:16] & wd;
      if (apb_wr && PADDR == OFS_FLAGS2) next_r.flags[53:32] = r.flags[53:32] & {6'h3F, wd};
      next_r.flags = (next_r.flags | SRC_EVENT) & SRC_IMPL_MASK;
      if (apb_wr && PADDR == OFS_EN0) next_r.enables[15:0]  = wd;
      if (apb_wr && PADDR == OFS_EN1) next_r.enables[31:16] = wd;
      if (apb_wr && PADDR == OFS_EN2) next_r.enables[53:32] = {6'h00, wd} & SRC_IMPL_MASK[53:32];
      if (apb_wr && hit_pri) next_r.pri[pri_idx] = wd & PRI_FIELD_MASK;
      if (apb_wr && PADDR == OFS_CTRL1)
         next_r.ctrl1 = (r.ctrl1 & ~CTRL1_WMASK) | (wd & CTRL1_WMASK);
      if (apb_wr && PADDR == OFS_CTRL2)
         next_r.ctrl2 = (r.ctrl2 & ~CTRL2_WMASK) | (wd & CTRL2_WMASK);
      // priority level writes locked while nesting disabled
      if (!r.ctrl1[CTRL1_NEST_DIS]) begin
         if (apb_wr && PADDR == OFS_CPUPRI) next_r.cpu_lvl = wd[3:0];
         if (CORE_SET_LEVEL) next_r.cpu_lvl = CORE_LEVEL;
      end
      // trap pending and status flags in first control register
      next_r.trap_pend = r.trap_pend | TRAP_EVENT | {2'b00, ADDR_ERR_TRAP, 1'b0};
      next_r.ctrl1[NUM_TRAP:1] = next_r.trap_pend;
      // timed mask counter
      if (TIMED_MASK_START) begin
         next_r.tmask_cnt = TIMED_MASK_COUNT;
      end else if (INSN_START && r.tmask_cnt != 14'h0) begin
         next_r.tmask_cnt = r.tmask_cnt - 14'h1;
      end
      if (apb_wr && PADDR == OFS_TMASK) next_r.tmask_cnt = wd[13:0];
      next_r.ctrl2[CTRL2_TMASK] = (next_r.tmask_cnt != 14'h0);
      // return from interrupt restores level
      if (IRQ_RETURN && r.depth != 4'h0) begin
         next_r.depth   = r.depth - 4'h1;
         next_r.cpu_lvl = {r.cpu_lvl[3], RETURN_STATUS_LOW[7:5]};
      end
      // vector area fetch check
      if (FETCH_VALID && FETCH_ADDR >= IVT_BASE && FETCH_ADDR <= VEC_AREA_LAST) begin
         next_r.addr_err = 1'b1;
      end
      unique case (r.state)
         PIC_IDLE: begin
            if (take) begin
               next_r.vec_num = cand_vec;
               next_r.new_lvl = cand_lvl;
               next_r.push    = 1'b1;
               next_r.push_pc = FETCH_ADDR;
               next_r.push_sl = {r.cpu_lvl[2:0], 5'h00};
               next_r.cpu_lvl = cand_lvl;
               next_r.depth   = r.depth + 4'h1;
               next_r.state   = PIC_FETCH;
               if (trap_any) next_r.trap_pend[trap_idx] = 1'b0;
               else next_r.flags[win_src] = next_r.flags[win_src];
            end
         end
         PIC_FETCH: begin
            if (PROG_RVALID) begin
               next_r.pc_value = PROG_RDATA;
               next_r.state    = PIC_LOAD;
            end
         end
         PIC_LOAD: begin
            next_r.pc_load = 1'b1;
            next_r.state   = PIC_IDLE;
         end
      endcase
      // read mux
      next_r.rdata = 32'h0;
      if (PSEL && !PENABLE && !PWRITE) begin
         unique case (PADDR)
            OFS_FLAGS0: next_r.rdata[15:0] = r.flags[15:0];
            OFS_FLAGS1: next_r.rdata[15:0] = r.flags[31:16];
            OFS_FLAGS2: next_r.rdata[21:0] = r.flags[53:32];
            OFS_EN0:    next_r.rdata[15:0] = r.enables[15:0];
            OFS_EN1:    next_r.rdata[15:0] = r.enables[31:16];
            OFS_EN2:    next_r.rdata[21:0] = r.enables[53:32];
            OFS_CTRL1:  next_r.rdata[15:0] = r.ctrl1;
            OFS_CTRL2:  next_r.rdata[15:0] = r.ctrl2;
            OFS_VSTAT:  next_r.rdata[15:0] = {4'h0, r.new_lvl, 2'b00, r.vec_num};
            OFS_CPUPRI: next_r.rdata[3:0]  = r.cpu_lvl;
            OFS_TMASK:  next_r.rdata[13:0] = r.tmask_cnt;
            default:    next_r.rdata[15:0] = hit_pri ? r.pri[pri_idx] : 16'h0;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         r       <= '0;
         r.pri   <= {NUM_PRI_REGS{PRI_RESET}};
         r.state <= PIC_IDLE;
      end else if (CLK_EN) begin
         r <= next_r;
      end
   end

   // outputs
   assign PREADY             = 1'b1;
   assign PSLVERR            = apb_acc && !mapped;
   assign PRDATA             = r.rdata;
   assign PROG_REQ           = (r.state == PIC_FETCH);
   assign PROG_ADDR          = (r.ctrl2[CTRL2_ALT_TBL] ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE)
                               + 24'({r.vec_num, 1'b0});
   assign PC_LOAD            = r.pc_load;
   assign PC_VALUE           = r.pc_value;
   assign STACK_PUSH         = r.push;
   assign STACK_PC           = r.push_pc;
   assign STACK_STATUS_LOW   = r.push_sl;
   assign CPU_PRIORITY_LEVEL = r.cpu_lvl;
   assign IN_SERVICE         = (r.depth != 4'h0);
   assign ADDR_ERR_TRAP      = r.addr_err;
endmodule

// ### hdl/pic_pkg.sv
// package: register map, field layout, reset values and state encoding for the interrupt controller
//
// Operation
// - arbitrate 43 interrupt sources plus four trap inputs under one priority scheme
// - request flags set by hardware, cleared only by software writes
// - flags set on their condition whatever the enable bit holds
// - a pending flag interrupts only while its own enable bit is set
// - each source takes priority 1 to 7, 7 highest, 1 lowest
// - a source at priority 0 is never taken
// - priority is low three bits of each nibble; nibble top bit reads zero
// - equal priorities resolve to the lowest source number
// - tie-break rank equals source number; vector number is source plus 8
// - sources sit at fixed positions; 41, 42, 45-53 reserved, never request
// - cpu priority is 4 bits: top bit in core control, low three in status
// - on acceptance latch 6-bit vector number and 4-bit new level, readable
// - with nesting disabled, no new interrupt starts while one is in service
// - while nesting disabled, software writes to cpu priority bits are ignored
// - timed mask blocks priorities 6 and below; its status bit stays set meanwhile
// - second control register sets external input edges and alternate table use
// - first control register holds trap control and status flags
// - on service pc loads the 24-bit vector slot; 63 vectors at 0x4 to 0xFE
// - instruction fetch from the vector area raises an address error trap
// - fetched vector enters pc through a 24-bit selector at its input
// - interrupt only when priority strictly exceeds cpu level; flags sampled each cycle
// - on entry push pc and status low byte, then load the accepted level
// - traps take levels 8 to 15, so they are serviced even at cpu level 7; traps 0 to 3 here take levels 11 to 14
package pic_pkg;
   localparam int          NUM_SRC        = 54;
   localparam int          NUM_TRAP       = 4;
   localparam logic [53:0] SRC_IMPL_MASK  = 54'h0000_19FF_FFFF_FFFF;
   localparam logic [5:0]  VEC_BASE       = 6'h08;
   localparam logic [23:0] IVT_BASE       = 24'h000004;
   localparam logic [23:0] ALTERNATE_VECTOR_TABLE_BASE      = 24'h000084;
   localparam logic [23:0] VEC_AREA_LAST  = 24'h0000FE;
   localparam logic [2:0]  TIMED_MASK_LVL = 3'h6;
   localparam logic [3:0]  TRAP_LVL_BASE  = 4'h8;
   // apb byte offsets
   localparam logic [7:0]  OFS_FLAGS0     = 8'h00;
   localparam logic [7:0]  OFS_FLAGS1     = 8'h04;
   localparam logic [7:0]  OFS_FLAGS2     = 8'h08;
   localparam logic [7:0]  OFS_EN0        = 8'h0C;
   localparam logic [7:0]  OFS_EN1        = 8'h10;
   localparam logic [7:0]  OFS_EN2        = 8'h14;
   localparam logic [7:0]  OFS_CTRL1      = 8'h18;
   localparam logic [7:0]  OFS_CTRL2      = 8'h1C;
   localparam logic [7:0]  OFS_VSTAT      = 8'h20;
   localparam logic [7:0]  OFS_CPUPRI     = 8'h24;
   localparam logic [7:0]  OFS_TMASK      = 8'h28;
   localparam logic [7:0]  OFS_PRI0       = 8'h40;
   localparam int          NUM_PRI_REGS   = 14;
   // field positions
   localparam int          CTRL1_NEST_DIS = 15;
   localparam int          CTRL2_ALT_TBL  = 15;
   localparam int          CTRL2_TMASK    = 14;
   localparam logic [15:0] CTRL1_WMASK    = 16'h8000;
   localparam logic [15:0] CTRL2_WMASK    = 16'h801F;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   localparam logic [15:0] PRI_RESET      = 16'h4444;
   localparam logic [15:0] PRI_FIELD_MASK = 16'h7777;
   localparam int          VSTAT_LVL_LSB  = 8;
   typedef enum logic [1:0] {PIC_IDLE, PIC_FETCH, PIC_LOAD} pic_state_t;
endpackage

// ### hdl/pic_prio_cell.sv
// one arbitration cell: keeps the stronger of two candidates
`timescale 1ns/100ps
module pic_prio_cell
   import pic_pkg::*;
(
   input  wire logic       A_VALID,
   input  wire logic [2:0] A_LVL,
   input  wire logic [5:0] A_SRC,
   input  wire logic       B_VALID,
   input  wire logic [2:0] B_LVL,
   input  wire logic [5:0] B_SRC,
   output logic            Y_VALID,
   output logic      [2:0] Y_LVL,
   output logic      [5:0] Y_SRC
);
   logic take_b;
   // a holds the lower source numbers, so it wins a tie
   assign take_b  = B_VALID && (!A_VALID || (B_LVL > A_LVL));
   assign Y_VALID = A_VALID || B_VALID;
   assign Y_LVL   = take_b ? B_LVL : A_LVL;
   assign Y_SRC   = take_b ? B_SRC : A_SRC;
endmodule

// ### dv/pic_core_model.sv
// core-side model: answers vector word reads after a chosen latency
`timescale 1ns/100ps
module pic_core_model
   import pic_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic [3:0]  LAT,
   input  wire logic        PROG_REQ,
   input  wire logic [23:0] PROG_ADDR,
   output logic             PROG_RVALID,
   output logic      [23:0] PROG_RDATA
);
   logic [3:0] cnt;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         cnt         <= 4'h0;
         PROG_RVALID <= 1'b0;
         PROG_RDATA  <= 24'h000000;
      end else begin
         PROG_RVALID <= 1'b0;
         PROG_RDATA  <= ~PROG_RDATA;
         cnt         <= 4'h0;
         if (PROG_REQ && !PROG_RVALID && cnt >= LAT) begin
            PROG_RVALID <= 1'b1;
            PROG_RDATA  <= {8'h1F, PROG_ADDR[15:0]};
         end else if (PROG_REQ && !PROG_RVALID)
            cnt <= cnt + 4'h1;
      end
   end
endmodule

// ### dv/pic_ctrl_checker.sv
// checker: core-side timing assertions for the interrupt controller
`timescale 1ns/100ps
module pic_ctrl_checker
   import pic_pkg::*;
(
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic        INSN_START,
   input wire logic        IRQ_RETURN,
   input wire logic        CORE_SET_LEVEL,
   input wire logic [23:0] FETCH_ADDR,
   input wire logic        FETCH_VALID,
   input wire logic [23:0] PROG_RDATA,
   input wire logic        PROG_RVALID,
   input wire logic [23:0] PROG_ADDR,
   input wire logic        PROG_REQ,
   input wire logic        PC_LOAD,
   input wire logic [23:0] PC_VALUE,
   input wire logic        STACK_PUSH,
   input wire logic [7:0]  STACK_STATUS_LOW,
   input wire logic [3:0]  CPU_PRIORITY_LEVEL,
   input wire logic        ADDR_ERR_TRAP
);
   logic [23:0] vec_word;
   always_ff @(posedge CLOCK or negedge RST_N)
      if (!RST_N) vec_word <= 24'h000000;
      else if (PROG_REQ && PROG_RVALID) vec_word <= PROG_RDATA;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   a_push_cause: assert property (STACK_PUSH |-> $past(INSN_START))
      else $error("push without instruction start");
   a_push_raises: assert property (STACK_PUSH |->
      CPU_PRIORITY_LEVEL > {1'b0, STACK_STATUS_LOW[7:5]}) else $error("level not raised");
   a_push_fetch: assert property (STACK_PUSH |-> PROG_REQ)
      else $error("no vector fetch after push");
   a_vec_addr: assert property (PROG_REQ |-> PROG_ADDR >= IVT_BASE &&
      PROG_ADDR <= VEC_AREA_LAST && !PROG_ADDR[0]) else $error("vector address out of area");
   a_load_follows: assert property (PROG_REQ && PROG_RVALID |-> ##[1:3] PC_LOAD)
      else $error("pc not loaded");
   a_pc_vector: assert property (PC_LOAD |-> PC_VALUE == vec_word)
      else $error("pc value differs from vector word");
   a_load_single: assert property (PC_LOAD |=> !PC_LOAD)
      else $error("pc load longer than one cycle");
   a_fetch_trap: assert property (FETCH_VALID && FETCH_ADDR >= IVT_BASE &&
      FETCH_ADDR <= VEC_AREA_LAST |-> ##[1:2] ADDR_ERR_TRAP) else $error("no address trap");
   a_trap_cause: assert property (ADDR_ERR_TRAP |->
      $past(FETCH_VALID) || $past(FETCH_VALID, 2)) else $error("address trap without fetch");
   a_level_cause: assert property ($changed(CPU_PRIORITY_LEVEL) |->
      $past(INSN_START) || $past(IRQ_RETURN) || $past(CORE_SET_LEVEL)
      || ($past(PSEL) && $past(PENABLE) && $past(PWRITE)))
      else $error("level changed without cause");
endmodule
bind pic_ctrl pic_ctrl_checker u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .INSN_START(INSN_START),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .IRQ_RETURN(IRQ_RETURN), .CORE_SET_LEVEL(CORE_SET_LEVEL), .FETCH_ADDR(FETCH_ADDR),
   .FETCH_VALID(FETCH_VALID), .PROG_RDATA(PROG_RDATA), .PROG_RVALID(PROG_RVALID),
   .PROG_ADDR(PROG_ADDR), .PROG_REQ(PROG_REQ), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
   .STACK_PUSH(STACK_PUSH), .STACK_STATUS_LOW(STACK_STATUS_LOW),
   .CPU_PRIORITY_LEVEL(CPU_PRIORITY_LEVEL), .ADDR_ERR_TRAP(ADDR_ERR_TRAP));

// ### dv/tb.sv
// testbench: register access and interrupt sequences for the interrupt controller
`timescale 1ns/100ps
module tb
   import pic_pkg::*;
;
   logic CLOCK = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic INSN_START = 1'b0, TIMED_MASK_START = 1'b0, IRQ_RETURN = 1'b0, CORE_SET_LEVEL = 1'b0;
   logic FETCH_VALID = 1'b0, PREADY, PSLVERR, PROG_RVALID, PROG_REQ, PC_LOAD, STACK_PUSH;
   logic IN_SERVICE, ADDR_ERR_TRAP, serr;
   logic [7:0]         PADDR = 8'h00, RETURN_STATUS_LOW = 8'h00, STACK_STATUS_LOW;
   logic [31:0]        PWDATA = 32'h00000000, PRDATA, rdat;
   logic [53:0]        SRC_EVENT = 54'h0;
   logic [3:0]         TRAP_EVENT = 4'h0, CORE_LEVEL = 4'h0, CPU_PRIORITY_LEVEL, lat = 4'h0;
   logic [13:0]        TIMED_MASK_COUNT = 14'h0000;
   logic [23:0]        FETCH_ADDR = 24'h000000, PROG_RDATA, PROG_ADDR, PC_VALUE, STACK_PC;
   int                 n_fail = 0, total_checks = 0;
   pic_ctrl uut (.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .SRC_EVENT(SRC_EVENT), .TRAP_EVENT(TRAP_EVENT),
      .INSN_START(INSN_START), .TIMED_MASK_START(TIMED_MASK_START),
      .TIMED_MASK_COUNT(TIMED_MASK_COUNT), .IRQ_RETURN(IRQ_RETURN),
      .RETURN_STATUS_LOW(RETURN_STATUS_LOW), .CORE_SET_LEVEL(CORE_SET_LEVEL),
      .CORE_LEVEL(CORE_LEVEL), .FETCH_ADDR(FETCH_ADDR), .FETCH_VALID(FETCH_VALID),
      .PROG_RDATA(PROG_RDATA), .PROG_RVALID(PROG_RVALID), .PROG_ADDR(PROG_ADDR),
      .PROG_REQ(PROG_REQ), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .STACK_PUSH(STACK_PUSH),
      .STACK_PC(STACK_PC), .STACK_STATUS_LOW(STACK_STATUS_LOW),
      .CPU_PRIORITY_LEVEL(CPU_PRIORITY_LEVEL), .IN_SERVICE(IN_SERVICE),
      .ADDR_ERR_TRAP(ADDR_ERR_TRAP));
   pic_core_model u_core (.CLOCK(CLOCK), .RST_N(RST_N), .LAT(lat), .PROG_REQ(PROG_REQ),
      .PROG_ADDR(PROG_ADDR), .PROG_RVALID(PROG_RVALID), .PROG_RDATA(PROG_RDATA));
   always #4 CLOCK = ~CLOCK;
   task end_of_test;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {16'h0000, d};
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (PREADY !== 1'b1) n_fail++;
      rdat = PRDATA;
      serr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 16'h0000);
      chk(rdat, e);
   endtask
   task ev(input logic [53:0] m);
      @(posedge CLOCK);
      SRC_EVENT <= m;
      @(posedge CLOCK);
      SRC_EVENT <= 54'h0;
   endtask
   task core(input logic r, input logic [3:0] l);
      @(posedge CLOCK);
      IRQ_RETURN <= r;
      CORE_SET_LEVEL <= !r;
      RETURN_STATUS_LOW <= {l[2:0], 5'h00};
      CORE_LEVEL <= l;
      @(posedge CLOCK);
      IRQ_RETURN <= 1'b0;
      CORE_SET_LEVEL <= 1'b0;
   endtask
   task irq(input logic t, input logic [5:0] v, input logic [3:0] l);
      logic seen;
      logic [23:0] pc;
      logic [23:0] sp;
      seen = 1'b0;
      pc = 24'h000000;
      sp = 24'h000000;
      @(posedge CLOCK);
      INSN_START <= 1'b1;
      @(posedge CLOCK);
      INSN_START <= 1'b0;
      repeat (30) begin
         #1;
         if (STACK_PUSH === 1'b1) begin
            seen = 1'b1;
            sp = STACK_PC;
         end
         if (PC_LOAD === 1'b1) pc = PC_VALUE;
         @(posedge CLOCK);
      end
      chk(32'(seen), 32'(t));
      if (t) chk(32'(CPU_PRIORITY_LEVEL), 32'(l));
      if (t) chk(32'(sp), 32'(FETCH_ADDR));
      if (t && v != 6'h3F) begin
         chk(32'(pc), 32'({8'h1F, IVT_BASE[15:0] + {9'h000, v, 1'b0}}));
         rc(OFS_VSTAT, {20'h00000, l, 2'b00, v});
      end
   endtask
   task fe(input logic [23:0] a, input logic e);
      logic seen;
      seen = 1'b0;
      @(posedge CLOCK);
      FETCH_ADDR <= a;
      FETCH_VALID <= 1'b1;
      @(posedge CLOCK);
      FETCH_VALID <= 1'b0;
      repeat (4) begin
         #1;
         if (ADDR_ERR_TRAP === 1'b1) seen = 1'b1;
         @(posedge CLOCK);
      end
      chk(32'(seen), 32'(e));
   endtask
   initial begin
      repeat (5000) @(posedge CLOCK);
      n_fail++;
      end_of_test;
   end
   initial begin
      repeat (4) @(posedge CLOCK);
      RST_N <= 1'b1;
      FETCH_ADDR <= 24'h000200;
      rc(OFS_FLAGS0, 32'h0);
      rc(OFS_EN0, 32'h0);
      rc(OFS_CTRL1, 32'h0);
      rc(OFS_VSTAT, 32'h0);
      rc(OFS_PRI0, 32'h4444);
      rc(8'h2C, 32'h0);
      chk(32'(serr), 32'h1);
      apb(1'b1, OFS_PRI0, 16'hFFFF);
      rc(OFS_PRI0, 32'h7777);
      ev(54'h0200_0000_0028);
      rc(OFS_FLAGS0, 32'h0028);
      rc(OFS_FLAGS2, 32'h0);
      apb(1'b1, OFS_FLAGS0, 16'hFFDF);
      rc(OFS_FLAGS0, 32'h0008);
      apb(1'b1, OFS_FLAGS0, 16'h0000);
      apb(1'b1, OFS_EN0, 16'h0028);
      apb(1'b1, OFS_PRI0, 16'h4000);
      ev(54'h28);
      irq(1'b1, 6'd11, 4'h4);
      core(1'b1, 4'h0);
      apb(1'b1, OFS_FLAGS0, 16'hFFF7);
      lat <= 4'h5;
      irq(1'b1, 6'd13, 4'h4);
      core(1'b1, 4'h0);
      core(1'b0, 4'h4);
      @(negedge CLOCK);
      chk(32'(CPU_PRIORITY_LEVEL), 32'h4);
      irq(1'b0, 6'd0, 4'h0);
      core(1'b0, 4'h3);
      irq(1'b1, 6'd13, 4'h4);
      core(1'b1, 4'h0);
      apb(1'b1, OFS_PRI0 + 8'h04, 16'h4404);
      irq(1'b0, 6'd0, 4'h0);
      apb(1'b1, OFS_PRI0 + 8'h04, 16'h4444);
      apb(1'b1, OFS_EN0, 16'h0000);
      irq(1'b0, 6'd0, 4'h0);
      apb(1'b1, OFS_EN0, 16'h0028);
      TIMED_MASK_COUNT <= 14'h0003;
      TIMED_MASK_START <= 1'b1;
      @(posedge CLOCK);
      TIMED_MASK_START <= 1'b0;
      rc(OFS_CTRL2, 32'h4000);
      irq(1'b0, 6'd0, 4'h0);
      apb(1'b1, OFS_EN0, 16'h0000);
      repeat (4) irq(1'b0, 6'd0, 4'h0);
      rc(OFS_CTRL2, 32'h0);
      apb(1'b1, OFS_EN0, 16'h0028);
      apb(1'b1, OFS_CTRL1, 16'h8000);
      core(1'b0, 4'h2);
      @(negedge CLOCK);
      chk(32'(CPU_PRIORITY_LEVEL), 32'h0);
      apb(1'b1, OFS_CPUPRI, 16'h0002);
      rc(OFS_CPUPRI, 32'h0);
      irq(1'b1, 6'd13, 4'h4);
      apb(1'b1, OFS_PRI0, 16'h7000);
      ev(54'h8);
      irq(1'b0, 6'd0, 4'h0);
      chk(32'(IN_SERVICE), 32'h1);
      core(1'b1, 4'h0);
      irq(1'b1, 6'd11, 4'h7);
      core(1'b1, 4'h0);
      apb(1'b1, OFS_EN0, 16'h0000);
      apb(1'b1, OFS_CTRL1, 16'h0000);
      core(1'b0, 4'h7);
      TRAP_EVENT <= 4'h1;
      @(posedge CLOCK);
      TRAP_EVENT <= 4'h0;
      irq(1'b1, 6'd1, 4'hB);
      fe(24'h000010, 1'b1);
      fe(24'h000100, 1'b0);
      fe(24'h000002, 1'b0);
      end_of_test;
   end
endmodule
